// ==== include/timer0_defs.vh ====
/*
 timer0 compare-output block: register addresses, field positions,
 reset values and waveform mode codes.
 assumes it is included by bare name from the rtl files.
*/
`ifndef TIMER0_DEFS_VH
`define TIMER0_DEFS_VH

`define CTRL_A_DATA_ADDR     8'h44
`define IO_SPACE_OFFSET      8'h20
`define IO_SPACE_LAST        8'h3F
`define CTRL_A_RESET         8'h00
`define CHAN_A_MODE_HI       7
`define CHAN_A_MODE_LO       6
`define CHAN_B_MODE_HI       5
`define CHAN_B_MODE_LO       4
`define WAVE_MODE_HI         1
`define WAVE_MODE_LO         0
`define CTRL_A_WRITE_MASK    8'hF3
`define COUNT_MAX            8'hFF
`define COUNT_BOTTOM         8'h00
`define WAVE_NORMAL          3'h0
`define WAVE_PHASE_FF        3'h1
`define WAVE_CLEAR_ON_MATCH  3'h2
`define WAVE_FAST_FF         3'h3
`define WAVE_PHASE_TOPA      3'h5
`define WAVE_FAST_TOPA       3'h7

`endif

// ==== rtl/timer0_channel.v ====
/*
 one compare-output channel: match flag and output waveform state.
 assumes count, direction and top come from the counter on the same clock.
*/
`timescale 1ns/100ps
`include "timer0_defs.vh"
module timer0_channel #(
  parameter IS_CHAN_A = 1
) (
  // clock and reset
  input  wire       clk,
  input  wire       resetn,
  // timer state
  input  wire       timerTickEnable,
  input  wire [7:0] timerCount,
  input  wire       countingDown,
  input  wire [7:0] topValue,
  input  wire [2:0] waveformMode,
  // channel config
  input  wire [1:0] outputMode,
  input  wire [7:0] compareValue,
  // results
  output reg        matchFlag,
  output reg        compareOut
);
  reg matchPending_reg;
  wire fastMode  = (waveformMode == `WAVE_FAST_FF) || (waveformMode == `WAVE_FAST_TOPA);
  wire phaseMode = (waveformMode == `WAVE_PHASE_FF) || (waveformMode == `WAVE_PHASE_TOPA);
  wire cmpAtTop  = (compareValue == topValue) && outputMode[1];
  wire atBottom  = (timerCount == `COUNT_BOTTOM);
  wire atTop     = (timerCount == topValue);
  // toggle in pwm only for channel A with upper mode bit
  wire pwmToggle = (IS_CHAN_A != 0) && waveformMode[2]; // RULE8

  always @(posedge clk) begin
    if (!resetn) begin
      matchPending_reg <= 1'b0;
      matchFlag        <= 1'b0;
      compareOut       <= 1'b0;
    end else begin
      matchFlag <= 1'b0;
      if (timerTickEnable) begin
        // flag lands on the tick after equality
        matchPending_reg <= (timerCount == compareValue);
        matchFlag        <= matchPending_reg; // RULE18
        if (!phaseMode && !fastMode) begin // RULE6
          if (timerCount == compareValue) begin
            case (outputMode) // RULE7 RULE14
              2'h1:    compareOut <= ~compareOut;
              2'h2:    compareOut <= 1'b0;
              2'h3:    compareOut <= 1'b1;
              default: compareOut <= compareOut;
            endcase
          end
        end else if (fastMode) begin
          if (outputMode == 2'h1) begin
            if (pwmToggle && timerCount == compareValue)
              compareOut <= ~compareOut;
          end else if (outputMode[1]) begin
            if (cmpAtTop && IS_CHAN_A != 0) begin
              if (atBottom)
                compareOut <= ~outputMode[0]; // RULE10
            end else if (cmpAtTop) begin
              // match at top ignored: top takes the bottom level, so no one-tick glitch
              if (atTop || atBottom)
                compareOut <= ~outputMode[0]; // RULE12
            end else if (timerCount == compareValue) begin
              compareOut <= outputMode[0]; // RULE9 RULE15
            end else if (atBottom) begin
              compareOut <= ~outputMode[0];
            end
          end
        end else begin
          if (outputMode == 2'h1) begin
            if (pwmToggle && timerCount == compareValue)
              compareOut <= ~compareOut;
          end else if (outputMode[1]) begin
            if (cmpAtTop) begin
              // level of a down-counting match, keeps the output symmetric around bottom
              if (atTop)
                compareOut <= ~outputMode[0]; // RULE12
            end else if (timerCount == compareValue) begin
              compareOut <= countingDown ? ~outputMode[0] : outputMode[0]; // RULE11 RULE16
            end
          end
        end
      end
    end
  end
endmodule

// ==== rtl/timer0_compare_output_control.v ====
/*
 timer0 control register A, counter and two compare-output channels with pin override.
 assumes a single synchronous I/O clock; the upper mode bit, compare values and
 direction bits arrive from same-clock logic; register port is byte wide.
*/
// What this block does
// RULE1: counter runs on the I/O clock, tick used as one-cycle enable.
// RULE2: asynchronous instances use the timer oscillator as their base clock instead; not built here, the counter runs on clk.
// RULE3: clear-on-match or fast PWM top A: match A sets flag, count returns zero.
// RULE4: control register also answers at data address minus 0x20, within 0x00-0x3F.
// RULE5: nonzero channel A mode overrides pin; driven only if direction bit is output.
// RULE6: output mode action depends on waveform mode: non-PWM, fast or phase-correct.
// RULE7: non-PWM channel A: 00 off, 01 toggle, 10 clear, 11 set on match.
// RULE8: PWM channel A code 01: port if upper bit 0, toggle on match if 1.
// RULE9: fast PWM A: 10 clear on match set at bottom; 11 inverse.
// RULE10: fast PWM A equals top with upper mode bit: ignore match, act at bottom.
// RULE11: phase-correct A: 10 clear on up match, set on down match; 11 reverse.
// RULE12: phase-correct both, fast B: compare equals top, upper bit: act at top.
// RULE13: nonzero channel B mode overrides pin; driven only if direction bit set.
// RULE14: non-PWM channel B: 00 off, 01 toggle, 10 clear, 11 set on match.
// RULE15: fast PWM B: 01 reserved; 10 clear match set bottom; 11 inverse.
// RULE16: phase-correct B: 01 reserved; 10 clear up, set down; 11 reverse.
// RULE17: modes 0 normal, 1/5 phase, 2 clear-on-match, 3/7 fast, 4/6 reserved.
// RULE18: match flag set on the tick after count equals compare value.
`timescale 1ns/100ps
`include "timer0_defs.vh"
module timer0_compare_output_control (
  // clock and reset
  input  wire       clk,
  input  wire       resetn,
  // register port
  input  wire [7:0] regAddr,
  input  wire       regIoSpace,
  input  wire       regWrite,
  input  wire       regRead,
  input  wire [7:0] regWriteData,
  output reg  [7:0] regReadData,
  output wire       regHit,
  // timer inputs
  input  wire       timerTickEnable,
  input  wire       waveformModeUpperBit,
  input  wire [7:0] chanACompareValue,
  input  wire [7:0] chanBCompareValue,
  // port pins
  input  wire       chanADirOut,
  input  wire       chanBDirOut,
  input  wire       chanAPortData,
  input  wire       chanBPortData,
  output wire       chanAComparePin,
  output wire       chanAComparePinOe,
  output wire       chanBComparePin,
  output wire       chanBComparePinOe,
  // timer state
  output wire [7:0] timerCount,
  output wire       chanAMatchFlag,
  output wire       chanBMatchFlag,
  output wire       timerClearPulse
);
  reg  [7:0] timer0ControlA_reg;
  wire [7:0] timer0ControlA_next;
  wire [1:0] chanAOutputMode = timer0ControlA_reg[`CHAN_A_MODE_HI:`CHAN_A_MODE_LO];
  wire [1:0] chanBOutputMode = timer0ControlA_reg[`CHAN_B_MODE_HI:`CHAN_B_MODE_LO];
  wire [2:0] waveformMode    = {waveformModeUpperBit, timer0ControlA_reg[`WAVE_MODE_HI:`WAVE_MODE_LO]};
  wire       countingDown;
  wire [7:0] topValue;
  wire       chanAOut;
  wire       chanBOut;

  // data space or io space (data address minus offset)
  function addrMatch;
    input [7:0] addr;
    input       ioSpace;
    begin
      if (ioSpace)
        addrMatch = (addr <= `IO_SPACE_LAST) && (addr == `CTRL_A_DATA_ADDR - `IO_SPACE_OFFSET); // RULE4
      else
        addrMatch = (addr == `CTRL_A_DATA_ADDR);
    end
  endfunction

  assign regHit = addrMatch(regAddr, regIoSpace);
  // bits 3:2 are unimplemented and read zero
  assign timer0ControlA_next = (regWrite && regHit) ? (regWriteData & `CTRL_A_WRITE_MASK) : timer0ControlA_reg;

  always @(posedge clk) begin
    if (!resetn)
      timer0ControlA_reg <= `CTRL_A_RESET;
    else
      timer0ControlA_reg <= timer0ControlA_next;
  end

  always @(posedge clk) begin
    if (!resetn)
      regReadData <= 8'h00;
    else if (regRead && regHit)
      regReadData <= timer0ControlA_reg;
    else
      regReadData <= 8'h00;
  end

  // a second clock domain is not built; the timer oscillator would drive clk here
  timer0_counter counter (
    .clk               (clk), // RULE2
    .resetn            (resetn),
    .timerTickEnable   (timerTickEnable),
    .waveformMode      (waveformMode), // RULE17
    .chanACompareValue (chanACompareValue),
    .timerCount        (timerCount),
    .countingDown      (countingDown),
    .topValue          (topValue)
  );

  timer0_channel #(.IS_CHAN_A(1)) channelA (
    .clk             (clk),
    .resetn          (resetn),
    .timerTickEnable (timerTickEnable),
    .timerCount      (timerCount),
    .countingDown    (countingDown),
    .topValue        (topValue),
    .waveformMode    (waveformMode),
    .outputMode      (chanAOutputMode),
    .compareValue    (chanACompareValue),
    .matchFlag       (chanAMatchFlag),
    .compareOut      (chanAOut)
  );

  timer0_channel #(.IS_CHAN_A(0)) channelB (
    .clk             (clk),
    .resetn          (resetn),
    .timerTickEnable (timerTickEnable),
    .timerCount      (timerCount),
    .countingDown    (countingDown),
    .topValue        (topValue),
    .waveformMode    (waveformMode),
    .outputMode      (chanBOutputMode),
    .compareValue    (chanBCompareValue),
    .matchFlag       (chanBMatchFlag),
    .compareOut      (chanBOut)
  );

  // count returns to zero on tick when top is compare A in single slope
  assign timerClearPulse = timerTickEnable && (timerCount == topValue) &&
                           ((waveformMode == `WAVE_CLEAR_ON_MATCH) || (waveformMode == `WAVE_FAST_TOPA)); // RULE3

  // pwm code 01 on A without upper bit leaves the port in charge
  wire pwmMode = waveformMode[0];
  wire chanAOverride = (chanAOutputMode != 2'h0) &&
                       !(pwmMode && chanAOutputMode == 2'h1 && !waveformMode[2]); // RULE5 RULE8
  wire chanBOverride = (chanBOutputMode != 2'h0); // RULE13

  assign chanAComparePin   = chanAOverride ? chanAOut : chanAPortData;
  assign chanAComparePinOe = chanADirOut; // RULE5
  assign chanBComparePin   = chanBOverride ? chanBOut : chanBPortData;
  assign chanBComparePinOe = chanBDirOut; // RULE13
endmodule

// ==== rtl/timer0_counter.v ====
/*
 8-bit timer count with single/dual slope and top selection.
 assumes timerTickEnable is a one-cycle enable on clk.
*/
`timescale 1ns/100ps
`include "timer0_defs.vh"
module timer0_counter (
  // clock and reset
  input  wire       clk,
  input  wire       resetn,
  // control
  input  wire       timerTickEnable,
  input  wire [2:0] waveformMode,
  input  wire [7:0] chanACompareValue,
  // state
  output reg  [7:0] timerCount,
  output reg        countingDown,
  output wire [7:0] topValue
);
  wire topIsA = (waveformMode == `WAVE_CLEAR_ON_MATCH) || (waveformMode == `WAVE_PHASE_TOPA) ||
                (waveformMode == `WAVE_FAST_TOPA);
  wire dualSlope = (waveformMode == `WAVE_PHASE_FF) || (waveformMode == `WAVE_PHASE_TOPA);
  assign topValue = topIsA ? chanACompareValue : `COUNT_MAX;

  always @(posedge clk) begin
    if (!resetn) begin
      timerCount   <= `COUNT_BOTTOM;
      countingDown <= 1'b0;
    end else if (timerTickEnable) begin // RULE1
      if (dualSlope) begin
        if (!countingDown && timerCount == topValue) begin
          countingDown <= 1'b1;
          timerCount   <= timerCount - 8'h01;
        end else if (countingDown && timerCount == `COUNT_BOTTOM) begin
          countingDown <= 1'b0;
          timerCount   <= timerCount + 8'h01;
        end else if (countingDown) begin
          timerCount <= timerCount - 8'h01;
        end else begin
          timerCount <= timerCount + 8'h01;
        end
      end else begin
        countingDown <= 1'b0;
        // return to zero after top match
        if (timerCount == topValue)
          timerCount <= `COUNT_BOTTOM; // RULE3
        else
          timerCount <= timerCount + 8'h01;
      end
    end
  end
endmodule

// ==== verification/tb_timer0_compare_output_control.sv ====
/*
 self-checking bench for timer0_compare_output_control with a pin load.
 assumes the checker is bound in; tick runs every clock in waveform tests.
*/
`timescale 1ns/100ps
module tb_timer0_compare_output_control;
  logic       clk = 1'b0, resetn = 1'b0, regIoSpace = 1'b0, regWrite = 1'b0, regRead = 1'b0;
  logic       timerTickEnable = 1'b0, waveformModeUpperBit = 1'b0, chanADirOut = 1'b1, chanBDirOut = 1'b1;
  logic       chanAPortData = 1'b0, chanBPortData = 1'b0;
  logic [7:0] regAddr = 8'h00, regWriteData = 8'h00, chanACompareValue = 8'h00, chanBCompareValue = 8'h00;
  logic [7:0] regReadData, timerCount, d;
  logic       regHit, chanAComparePin, chanAComparePinOe, chanBComparePin, chanBComparePinOe;
  logic       chanAMatchFlag, chanBMatchFlag, timerClearPulse, padA, padB;
  int         n_errors = 0, n_compared = 0, cycles = 0, hiA, hiB, flagsA, flagsB, maxCnt;
  timer0_compare_output_control u_timer0_compare_output_control (.*);
  timer0_pin_load u_timer0_pin_load (.pinA(chanAComparePin), .oeA(chanAComparePinOe), .pinB(chanBComparePin),
    .oeB(chanBComparePinOe), .padA(padA), .padB(padB));
  always #4 clk = ~clk;
  // hang guard, runs take about 4400 cycles
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      n_errors++;
      end_sim();
    end
  end
  task automatic near(string what, int exp, int got, int tol);
    n_compared++;
    if (got > exp + tol || got + tol < exp) begin
      n_errors++;
      $display("[FAIL] %s expected %0d seen %0d", what, exp, got);
    end
  endtask
  task automatic check(string what, logic [7:0] exp, logic [7:0] got);
    n_compared++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr(logic io, logic [7:0] a, logic [7:0] v);
    @(posedge clk) #1;
    regIoSpace = io;
    regAddr = a;
    regWriteData = v;
    regWrite = 1'b1;
    @(posedge clk) #1;
    regWrite = 1'b0;
  endtask
  task automatic rd(logic io, logic [7:0] a);
    @(posedge clk) #1;
    regIoSpace = io;
    regAddr = a;
    regRead = 1'b1;
    @(posedge clk) #1;
    regRead = 1'b0;
    d = regReadData;
  endtask
  task automatic run(int n);
    hiA = 0;
    hiB = 0;
    flagsA = 0;
    flagsB = 0;
    maxCnt = 0;
    repeat (n) begin
      @(posedge clk) #1;
      hiA += padA;
      hiB += padB;
      flagsA += chanAMatchFlag;
      flagsB += chanBMatchFlag;
      if (timerCount > maxCnt) maxCnt = timerCount;
    end
  endtask
  task automatic t_regs();
    rd(1'b0, 8'h44);
    check("reset value", 8'h00, d);
    wr(1'b1, 8'h24, 8'hFF);
    rd(1'b0, 8'h44);
    check("io alias write", 8'hF3, d);
    rd(1'b0, 8'h45);
    check("unmapped read", 8'h00, d);
    $display("test regs done");
  endtask
  task automatic t_port();
    wr(1'b0, 8'h44, 8'h00);
    chanAPortData = 1'b1;
    chanBPortData = 1'b1;
    chanADirOut = 1'b0;
    @(posedge clk) #1;
    check("pin A port data", 8'h01, {7'h00, chanAComparePin});
    check("pin B port data", 8'h01, {7'h00, chanBComparePin});
    chanAPortData = 1'b0;
    @(posedge clk) #1;
    check("pin A port low", 8'h00, {7'h00, chanAComparePin});
    check("pad A released", 8'h01, {7'h00, padA});
    chanAPortData = 1'b1;
    chanADirOut = 1'b1;
    $display("test port done");
  endtask
  task automatic t_ctc();
    timerTickEnable = 1'b1;
    chanACompareValue = 8'h03;
    chanBCompareValue = 8'h01;
    wr(1'b0, 8'h44, 8'h72);
    run(8);
    run(40);
    near("ctc top", 3, maxCnt, 0);
    near("toggle high", 20, hiA, 4);
    near("flags", 10, flagsA, 1);
    near("set B", 40, hiB, 0);
    near("flags B", 10, flagsB, 1);
    wr(1'b0, 8'h44, 8'hE2);
    run(8);
    run(40);
    near("set A", 40, hiA, 0);
    near("clear B", 0, hiB, 0);
    $display("test ctc done");
  endtask
  task automatic t_fast();
    chanACompareValue = 8'h40;
    chanBCompareValue = 8'h80;
    wr(1'b0, 8'h44, 8'hB3);
    run(300);
    run(512);
    near("fast A high", 128, hiA, 4);
    near("fast B high", 256, hiB, 4);
    chanACompareValue = 8'hFF;
    run(300);
    run(256);
    near("fast A at top", 256, hiA, 0);
    chanACompareValue = 8'h40;
    wr(1'b0, 8'h44, 8'h43);
    run(300);
    near("A toggle off", 300, hiA, 0);
    waveformModeUpperBit = 1'b1;
    run(300);
    run(260);
    near("A toggle on", 130, hiA, 4);
    near("flags top A", 4, flagsA, 1);
    waveformModeUpperBit = 1'b0;
    $display("test fast done");
  endtask
  task automatic t_phase();
    wr(1'b0, 8'h44, 8'hB1);
    run(520);
    run(510);
    near("phase A high", 128, hiA, 4);
    near("phase B high", 254, hiB, 4);
    chanACompareValue = 8'hFF;
    run(520);
    run(510);
    near("phase A at top", 510, hiA, 0);
    $display("test phase done");
  endtask
  task automatic end_sim();
    $display("compared %0d mismatches %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  initial begin
    repeat (10) @(posedge clk);
    #1 resetn = 1'b1;
    t_regs();
    t_port();
    t_ctc();
    t_fast();
    t_phase();
    end_sim();
  end
endmodule

// ==== verification/timer0_compare_output_control_chk.sv ====
/*
 port checker for timer0_compare_output_control.
 assumes it is bound onto the top module, ports matched by name.
*/
`timescale 1ns/100ps
module timer0_compare_output_control_chk (
  input logic       clk,
  input logic       resetn,
  input logic [7:0] regAddr,
  input logic       regIoSpace,
  input logic       regWrite,
  input logic       regRead,
  input logic [7:0] regWriteData,
  input logic [7:0] regReadData,
  input logic       regHit,
  input logic       timerTickEnable,
  input logic       waveformModeUpperBit,
  input logic [7:0] chanACompareValue,
  input logic       chanADirOut,
  input logic       chanBDirOut,
  input logic       chanAPortData,
  input logic       chanAComparePin,
  input logic       chanAComparePinOe,
  input logic       chanBComparePinOe,
  input logic [7:0] timerCount,
  input logic       chanAMatchFlag,
  input logic       timerClearPulse
);
  logic [7:0] ctrlReg;
  wire        nonPwm = !waveformModeUpperBit && !ctrlReg[0];
  wire        fastFF = !waveformModeUpperBit && ctrlReg[1:0] == 2'h3;
  // shadow of the control register, reserved bits dropped
  always @(posedge clk)
    if (!resetn) ctrlReg <= 8'h00;
    else if (regWrite && regHit) ctrlReg <= regWriteData & 8'hF3;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  sequence s_match_a;
    timerTickEnable && timerCount == chanACompareValue;
  endsequence
  sequence s_bottom_a;
    timerTickEnable && timerCount == 8'h00;
  endsequence
  a_oe_follows_dir: assert property (chanAComparePinOe == chanADirOut && chanBComparePinOe == chanBDirOut)
    else $error("pin enable differs from direction");
  a_hit_decode: assert property (regHit == (regAddr == (regIoSpace ? 8'h24 : 8'h44)))
    else $error("address decode wrong");
  a_miss_reads_zero: assert property (regRead && !regHit |=> regReadData == 8'h00)
    else $error("miss read not zero");
  a_read_returns_reg: assert property (regRead && regHit && !regWrite |=> regReadData == $past(ctrlReg))
    else $error("read data wrong");
  a_count_holds: assert property (!timerTickEnable |=> $stable(timerCount))
    else $error("count moved without tick");
  a_flag_on_tick: assert property (chanAMatchFlag |-> $past(timerTickEnable))
    else $error("flag outside tick");
  a_clear_to_zero: assert property (timerClearPulse |-> timerTickEnable ##1 timerCount == 8'h00)
    else $error("count not cleared");
  a_port_passes: assert property (ctrlReg[7:6] == 2'b00 |-> chanAComparePin == chanAPortData)
    else $error("port data not on pin");
  a_set_on_match: assert property ((nonPwm && ctrlReg[7:6] == 2'b11 && !regWrite) ##0 s_match_a |=> chanAComparePin)
    else $error("set on match missed");
  a_set_at_bottom: assert property ((fastFF && ctrlReg[7:6] == 2'b10 && !regWrite
    && chanACompareValue inside {[8'h01:8'hFE]}) ##0 s_bottom_a |=> chanAComparePin)
    else $error("set at bottom missed");
endmodule
bind timer0_compare_output_control timer0_compare_output_control_chk u_chk (.*);

// ==== verification/timer0_pin_load.sv ====
/*
 external load on the two compare pins: resolves each pad level.
 assumes pull-ups on both pads, so an undriven pad reads high.
*/
`timescale 1ns/100ps
module timer0_pin_load (
  // pins from the block
  input  wire pinA,
  input  wire oeA,
  input  wire pinB,
  input  wire oeB,
  // pad levels seen by the load
  output wire padA,
  output wire padB
);
  assign padA = oeA ? pinA : 1'b1;
  assign padB = oeB ? pinB : 1'b1;
endmodule
